// ==== src/iss_pkg.sv ====
// Package of constants for the interrupt source selector
package iss_pkg;

   // ****************************************************************
   // Register map and field layout
   // ****************************************************************
   localparam logic [31:0] ISS_SEL_HIGH_ADDR  = 32'h019C0000;
   localparam logic [31:0] ISS_SEL_LOW_ADDR   = 32'h019C0004;
   localparam int          ISS_SEL_W          = 5;
   localparam int          ISS_FIELDS_PER_REG = 6;
   localparam int          ISS_NUM_LINES      = 16;
   localparam int          ISS_FIRST_SEL_LINE = 4;
   localparam int          ISS_NUM_SRC        = 32;
   // Low bit of each field inside its register (bits 15 and 31 unused)
   localparam int          ISS_FIELD_LSB [ISS_FIELDS_PER_REG] = '{0, 5, 10, 16, 21, 26};
   localparam logic [31:0] ISS_SEL_MASK       = 32'h7FFF7FFF;

   // ****************************************************************
   // Reset values (lines 4..9 low, 10..15 high)
   // ****************************************************************
   localparam logic [31:0] ISS_SEL_LOW_RST  = {1'h0, 5'h09, 5'h08, 5'h07, 1'h0, 5'h06, 5'h05, 5'h04};
   localparam logic [31:0] ISS_SEL_HIGH_RST = {1'h0, 5'h02, 5'h01, 5'h00, 1'h0, 5'h0B, 5'h0A, 5'h03};

   // ****************************************************************
   // Selector codes
   // ****************************************************************
   localparam logic [4:0] ISS_SRC_HOST      = 5'h00;
   localparam logic [4:0] ISS_SRC_TIMER0    = 5'h01;
   localparam logic [4:0] ISS_SRC_TIMER1    = 5'h02;
   localparam logic [4:0] ISS_SRC_MEMA      = 5'h03;
   localparam logic [4:0] ISS_SRC_PIN4      = 5'h04;
   localparam logic [4:0] ISS_SRC_DMA       = 5'h08;
   localparam logic [4:0] ISS_SRC_EMU_DMA   = 5'h09;
   localparam logic [4:0] ISS_SRC_DBG_RX    = 5'h0A;
   localparam logic [4:0] ISS_SRC_DBG_TX    = 5'h0B;
   localparam logic [4:0] ISS_SRC_SER0_TX   = 5'h0C;
   localparam logic [4:0] ISS_SRC_SER0_RX   = 5'h0D;
   localparam logic [4:0] ISS_SRC_SER1_TX   = 5'h0E;
   localparam logic [4:0] ISS_SRC_SER1_RX   = 5'h0F;
   localparam logic [4:0] ISS_SRC_PIN0      = 5'h10;
   localparam logic [4:0] ISS_SRC_SER2_TX   = 5'h11;
   localparam logic [4:0] ISS_SRC_SER2_RX   = 5'h12;
   localparam logic [4:0] ISS_SRC_TIMER2    = 5'h13;
   localparam logic [4:0] ISS_SRC_MEMB      = 5'h14;
   localparam logic [4:0] ISS_SRC_CELL      = 5'h17;
   localparam logic [4:0] ISS_SRC_VITERBI   = 5'h1E;
   localparam logic [4:0] ISS_SRC_TURBO     = 5'h1F;

   // ****************************************************************
   // Pin control register address, reset value and field positions
   // ****************************************************************
   localparam logic [31:0] ISS_PIN_CTRL_ADDR = 32'h019C0008;
   localparam logic [31:0] ISS_PIN_CTRL_RST  = 32'h00000000;
   localparam int          ISS_PIN_EN_LSB    = 0;
   localparam int          ISS_PIN_DIR_LSB   = 16;

endpackage

// ==== src/iss_line_sel.sv ====
// One maskable line: selects one of the event sources by code
`timescale 1ns/100ps
`default_nettype none
module iss_line_sel
   import iss_pkg::*;
(
   // Clock and reset
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_srst,
   // Sources and selector
   input  wire logic [ISS_NUM_SRC-1:0] i_sources,
   input  wire logic [ISS_SEL_W-1:0] i_sel,
   // Line out
   output logic                      o_line
);

   logic line_q;
   logic next_line;

   // Reserved codes are tied low in i_sources, so they give no events
   always_comb begin
      next_line = i_sources[i_sel];
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         line_q <= 1'b0;
      end else begin
         line_q <= next_line;
      end
   end

   assign o_line = line_q;

endmodule
`default_nettype wire

// ==== src/iss_top.sv ====
// Interrupt source selector with APB register access
//
// Summary of operation
// - Sixteen prioritised lines, zero highest, reset
// - Lines 0-3 fixed: reset, NMI, reserved
// - Lines 4-15 follow selector, documented defaults
// - High register 0x019C0000, low 0x019C0004
// - Low register fields five bits, gaps 15,31
// - High register same layout, lines 10-15
// - Reset codes per line as documented
// - Codes 0-11: host, timers, pins, DMA, debug
// - Codes 12-31: serial, pin0, timer2, cell, coprocs
// - Pins 4-7 are external interrupt inputs
// - Clock-shared pins keep clock until enabled
// - PCI-shared pins default to no function
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module iss_top
   import iss_pkg::*;
(
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_srst,
   // APB slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [31:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic             o_pready,
   output logic             o_pslverr,
   output logic [31:0]      o_prdata,
   // Fixed sources, same clock domain
   input  wire logic        i_reset_event,
   input  wire logic        i_nmi_event,
   // Peripheral events, same clock domain
   input  wire logic        i_host_event,
   input  wire logic        i_timer0_event,
   input  wire logic        i_timer1_event,
   input  wire logic        i_timer2_event,
   input  wire logic        i_memctl_a_refresh_timer_event,
   input  wire logic        i_memctl_b_refresh_timer_event,
   input  wire logic        i_dma_completion_event,
   input  wire logic        i_emulation_dma_event,
   input  wire logic        i_debug_exchange_receive_event,
   input  wire logic        i_debug_exchange_transmit_event,
   input  wire logic        i_serial0_transmit_event,
   input  wire logic        i_serial0_receive_event,
   input  wire logic        i_serial1_transmit_event,
   input  wire logic        i_serial1_receive_event,
   input  wire logic        i_serial2_transmit_event,
   input  wire logic        i_serial2_receive_event,
   input  wire logic        i_cell_interface_event,
   input  wire logic        i_viterbi_coproc_event,
   input  wire logic        i_turbo_coproc_event,
   input  wire logic        i_pin_event_0,
   // External pins 4..7, asynchronous
   input  wire logic [3:0]  i_external_pin_events,
   // Interrupt lines to the core
   output logic [15:0]      o_core_int,
   // Pin function controls
   output logic [15:0]      o_pin_general_enable,
   output logic [15:0]      o_pin_direction
);

   // ****************************************************************
   // Register state
   // ****************************************************************
   logic [31:0] sel_high;
   logic [31:0] sel_low;
   logic [31:0] pin_ctrl;
   logic [31:0] next_sel_high;
   logic [31:0] next_sel_low;
   logic [31:0] next_pin_ctrl;
   logic [31:0] prdata;
   logic [31:0] next_prdata;
   logic        wr_en;
   logic        rd_en;
   logic        addr_hit;

   // One-cycle answer: access phase always completes at once
   assign o_pready  = 1'b1;
   assign wr_en     = i_psel && i_penable && i_pwrite;
   assign rd_en     = i_psel && !i_penable && !i_pwrite;
   assign addr_hit  = (i_paddr == ISS_SEL_HIGH_ADDR) || (i_paddr == ISS_SEL_LOW_ADDR) ||
                      (i_paddr == ISS_PIN_CTRL_ADDR);
   assign o_pslverr = i_psel && i_penable && !addr_hit;

   // Register writes; unused bits 15 and 31 stay zero
   always_comb begin
      next_sel_high = sel_high;
      next_sel_low  = sel_low;
      next_pin_ctrl = pin_ctrl;
      if (wr_en && (i_paddr == ISS_SEL_HIGH_ADDR)) begin
         next_sel_high = i_pwdata & ISS_SEL_MASK;
      end
      if (wr_en && (i_paddr == ISS_SEL_LOW_ADDR)) begin
         next_sel_low = i_pwdata & ISS_SEL_MASK;
      end
      if (wr_en && (i_paddr == ISS_PIN_CTRL_ADDR)) begin
         next_pin_ctrl = i_pwdata;
      end
   end

   // Read data captured in setup so it is registered in access phase
   always_comb begin
      next_prdata = prdata;
      if (rd_en) begin
         case (i_paddr)
            ISS_SEL_HIGH_ADDR: next_prdata = sel_high;
            ISS_SEL_LOW_ADDR:  next_prdata = sel_low;
            ISS_PIN_CTRL_ADDR: next_prdata = pin_ctrl;
            default:           next_prdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         sel_high <= ISS_SEL_HIGH_RST;
         sel_low  <= ISS_SEL_LOW_RST;
         pin_ctrl <= ISS_PIN_CTRL_RST;
         prdata   <= 32'h00000000;
      end else begin
         sel_high <= next_sel_high;
         sel_low  <= next_sel_low;
         pin_ctrl <= next_pin_ctrl;
         prdata   <= next_prdata;
      end
   end

   assign o_prdata = prdata;

   // Zero enables leave shared pins in clock or no-function state
   assign o_pin_general_enable = pin_ctrl[ISS_PIN_EN_LSB +: 16];
   assign o_pin_direction      = pin_ctrl[ISS_PIN_DIR_LSB +: 16];

   // ****************************************************************
   // External pin synchroniser
   // ****************************************************************
   logic [3:0] ext_meta;
   logic [3:0] ext_sync;

   // Pins 4..7 are inputs after reset, so no direction gate here
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         ext_meta <= 4'h0;
         ext_sync <= 4'h0;
      end else begin
         ext_meta <= i_external_pin_events;
         ext_sync <= ext_meta;
      end
   end

   // ****************************************************************
   // Source vector by code
   // ****************************************************************
   logic [ISS_NUM_SRC-1:0] sources;

   // Reserved codes 15h, 16h, 18h..1Dh stay zero
   always_comb begin
      sources                                   = '0;
      sources[ISS_SRC_HOST]                     = i_host_event;
      sources[ISS_SRC_TIMER0]                   = i_timer0_event;
      sources[ISS_SRC_TIMER1]                   = i_timer1_event;
      sources[ISS_SRC_MEMA]                     = i_memctl_a_refresh_timer_event;
      sources[ISS_SRC_PIN4 +: 4]                = ext_sync;
      sources[ISS_SRC_DMA]                      = i_dma_completion_event;
      sources[ISS_SRC_EMU_DMA]                  = i_emulation_dma_event;
      sources[ISS_SRC_DBG_RX]                   = i_debug_exchange_receive_event;
      sources[ISS_SRC_DBG_TX]                   = i_debug_exchange_transmit_event;
      sources[ISS_SRC_SER0_TX]                  = i_serial0_transmit_event;
      sources[ISS_SRC_SER0_RX]                  = i_serial0_receive_event;
      sources[ISS_SRC_SER1_TX]                  = i_serial1_transmit_event;
      sources[ISS_SRC_SER1_RX]                  = i_serial1_receive_event;
      sources[ISS_SRC_PIN0]                     = i_pin_event_0;
      sources[ISS_SRC_SER2_TX]                  = i_serial2_transmit_event;
      sources[ISS_SRC_SER2_RX]                  = i_serial2_receive_event;
      sources[ISS_SRC_TIMER2]                   = i_timer2_event;
      sources[ISS_SRC_MEMB]                     = i_memctl_b_refresh_timer_event;
      sources[ISS_SRC_CELL]                     = i_cell_interface_event;
      sources[ISS_SRC_VITERBI]                  = i_viterbi_coproc_event;
      sources[ISS_SRC_TURBO]                    = i_turbo_coproc_event;
   end

   // ****************************************************************
   // Line outputs
   // ****************************************************************
   // A net, since the fixed bits and each selector instance drive separate slices
   wire logic [ISS_NUM_LINES-1:0]      lines;
   logic      [ISS_FIRST_SEL_LINE-1:0] fixed_q;
   logic      [ISS_FIRST_SEL_LINE-1:0] next_fixed;

   // Lines 0..3 registered so all lines share one cycle of latency
   always_comb begin
      next_fixed    = '0;
      next_fixed[0] = i_reset_event;
      next_fixed[1] = i_nmi_event;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         fixed_q <= '0;
      end else begin
         fixed_q <= next_fixed;
      end
   end

   assign lines[3:0] = fixed_q[3:0];

   genvar g;
   generate
      for (g = 0; g < 2 * ISS_FIELDS_PER_REG; g++) begin : g_line
         logic [ISS_SEL_W-1:0] sel;
         // Lines 4..9 from low register, 10..15 from high
         if (g < ISS_FIELDS_PER_REG) begin : g_lo
            assign sel = sel_low[ISS_FIELD_LSB[g] +: ISS_SEL_W];
         end else begin : g_hi
            assign sel = sel_high[ISS_FIELD_LSB[g-ISS_FIELDS_PER_REG] +: ISS_SEL_W];
         end
         iss_line_sel u_sel (
            .i_ref_clk (i_ref_clk),
            .i_srst    (i_srst),
            .i_sources (sources),
            .i_sel     (sel),
            .o_line    (lines[ISS_FIRST_SEL_LINE+g])
         );
      end
   endgenerate

   assign o_core_int = lines;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   sequence s_write_high;
      i_psel && i_penable && i_pwrite && (i_paddr == ISS_SEL_HIGH_ADDR);
   endsequence

   a_high_write_lands: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      s_write_high |=> (sel_high == ($past(i_pwdata) & ISS_SEL_MASK)))
      else $error("high selector write lost");

   a_low_gap_bits: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (sel_low[15] == 1'b0) && (sel_low[31] == 1'b0))
      else $error("low selector gap bit set");

   a_high_gap_bits: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (sel_high[15] == 1'b0) && (sel_high[31] == 1'b0))
      else $error("high selector gap bit set");

   a_reset_defaults: assert property (@(posedge i_ref_clk)
      $past(i_srst) |-> (sel_low == ISS_SEL_LOW_RST) && (sel_high == ISS_SEL_HIGH_RST))
      else $error("selector reset value wrong");

   a_line4_follows: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      ##1 o_core_int[4] == $past(sources[sel_low[4:0]]))
      else $error("line 4 does not follow its source");

   a_line15_follows: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      ##1 o_core_int[15] == $past(sources[sel_high[30:26]]))
      else $error("line 15 does not follow its source");

   a_nmi_line: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      i_nmi_event |=> o_core_int[1])
      else $error("nmi line not driven");

   a_reserved_lines: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      o_core_int[3:2] == 2'h0)
      else $error("reserved line active");

   a_ext_sync_delay: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      ##2 ext_sync == $past(i_external_pin_events, 2))
      else $error("external pin sync delay wrong");

   a_pins_default: assert property (@(posedge i_ref_clk)
      $past(i_srst) |-> (o_pin_general_enable == 16'h0000))
      else $error("pin enables not cleared by reset");

endmodule
`default_nettype wire

// ==== verif/iss_src_model.sv ====
// Event source model standing on the far side of the selector
`timescale 1ns/100ps
`default_nettype none
module iss_src_model (
   // Requests from the bench
   input  wire logic [31:0] i_fire,
   input  wire logic [1:0]  i_fix,
   // Event levels towards the selector
   output logic [31:0]      o_src,
   output logic [1:0]       o_fixed
);
   // Positions that name a real source; the rest never carry an event
   localparam logic [31:0] ISS_REAL_SRC = 32'hC09FFFFF;

   // Events are plain levels held as long as the bench asks for them
   always_comb begin
      o_src   = i_fire & ISS_REAL_SRC;
      o_fixed = i_fix;                 // Reset and nonmaskable sources
   end
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking testbench for the interrupt source selector
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import iss_pkg::*;
   // ****************************************************************
   // Signals
   // ****************************************************************
   localparam logic [31:0] VALID = 32'hC09FFFFF;
   logic        clk     = 1'b0;
   logic        srst    = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [31:0] paddr   = 32'h0;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] fire    = 32'h0;
   logic [1:0]  fix     = 2'h0;
   logic [31:0] lo      = 32'h250718A4;
   logic [31:0] hi      = 32'h08202D43;
   logic        pready;
   logic        pslverr;
   logic [31:0] prdata;
   logic [31:0] src;
   logic [1:0]  fixed;
   logic [15:0] core_int;
   logic [15:0] pin_en;
   logic [15:0] pin_dir;
   logic [31:0] rdat;
   logic        err;
   int          bad_count  = 0;
   int          num_checks = 0;
   int          c;

   // 100 MHz clock
   always #5 clk = ~clk;

   iss_src_model model (.i_fire(fire), .i_fix(fix), .o_src(src), .o_fixed(fixed));

   iss_top dut (
      .i_ref_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
      .i_reset_event(fixed[0]), .i_nmi_event(fixed[1]), .i_host_event(src[0]),
      .i_timer0_event(src[1]), .i_timer1_event(src[2]), .i_timer2_event(src[19]),
      .i_memctl_a_refresh_timer_event(src[3]), .i_memctl_b_refresh_timer_event(src[20]),
      .i_dma_completion_event(src[8]), .i_emulation_dma_event(src[9]),
      .i_debug_exchange_receive_event(src[10]), .i_debug_exchange_transmit_event(src[11]),
      .i_serial0_transmit_event(src[12]), .i_serial0_receive_event(src[13]),
      .i_serial1_transmit_event(src[14]), .i_serial1_receive_event(src[15]),
      .i_serial2_transmit_event(src[17]), .i_serial2_receive_event(src[18]),
      .i_cell_interface_event(src[23]), .i_viterbi_coproc_event(src[30]),
      .i_turbo_coproc_event(src[31]), .i_pin_event_0(src[16]), .i_external_pin_events(src[7:4]),
      .o_core_int(core_int), .o_pin_general_enable(pin_en), .o_pin_direction(pin_dir)
   );

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One APB transfer; the wait for pready is bounded so a stuck slave ends the run
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         bad_count++;
         summarize();
      end
      rdat = prdata;
      err  = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [31:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rdat);
   endtask

   // Expected lines for a set of firing sources under the shadow selectors
   function automatic logic [15:0] expv(input logic [31:0] fv);
      logic [15:0] v;
      logic [4:0]  s;
      int          f;
      v = 16'h0;
      for (int l = 0; l < 12; l++) begin
         f = l % 6;
         s = (l < 6) ? lo[f*5+(f > 2 ? 1 : 0) +: 5] : hi[f*5+(f > 2 ? 1 : 0) +: 5];
         v[l+4] = fv[s] & VALID[s];
      end
      return v;
   endfunction

   // Fire, wait past the two-cycle pin synchroniser, check, release, check quiet
   task automatic ev(input logic [31:0] fv);
      @(posedge clk);
      fire <= fv;
      repeat (5) @(posedge clk);
      chk("lines_on", {16'h0, expv(fv)}, {16'h0, core_int});
      fire <= 32'h0;
      repeat (5) @(posedge clk);
      chk("lines_off", 32'h0, {16'h0, core_int});
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      rdchk(ISS_SEL_HIGH_ADDR, 32'h08202D43, "sel_high");
      rdchk(ISS_SEL_LOW_ADDR, 32'h250718A4, "sel_low");
      rdchk(ISS_PIN_CTRL_ADDR, 32'h0, "pin_ctrl");
      chk("pin_en", 32'h0, {16'h0, pin_en});
      $display("test reset_values done");
      for (c = 0; c < 12; c++) ev(32'h1 << c);
      $display("test default_routing done");
      fix  <= 2'h3;
      fire <= 32'hFFFFFFFF;
      repeat (5) @(posedge clk);
      chk("fixed_lines", 32'h3, {28'h0, core_int[3:0]});
      fix  <= 2'h0;
      fire <= 32'h0;
      repeat (5) @(posedge clk);
      chk("fixed_off", 32'h0, {16'h0, core_int});
      $display("test fixed_lines done");
      // Every legal code on lines 4 and 15; a reserved code is never written, so the
      // last code stays and all other sources fire, which must leave both lines quiet
      for (c = 0; c < 32; c++) begin
         if (VALID[c]) begin
            lo = {lo[31:5], c[4:0]};
            hi = {hi[31], c[4:0], hi[25:0]};
         end
         apb(1'b1, ISS_SEL_LOW_ADDR, lo);
         apb(1'b1, ISS_SEL_HIGH_ADDR, hi);
         rdchk(ISS_SEL_LOW_ADDR, lo, "sel_low_rw");
         ev(VALID[c] ? 32'h1 << c : ~(32'h1 << lo[4:0]));
      end
      $display("test all_codes done");
      apb(1'b1, ISS_SEL_HIGH_ADDR, 32'hFFFFFFFF);
      hi = 32'h7FFF7FFF;
      rdchk(ISS_SEL_HIGH_ADDR, hi, "sel_gaps");
      ev(32'h80000000);
      $display("test field_gaps done");
      apb(1'b0, 32'h019C0010, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, err});
      chk("unmapped_rd", 32'h0, rdat);
      apb(1'b1, 32'h019C0010, 32'h0);
      rdchk(ISS_SEL_HIGH_ADDR, hi, "sel_kept");
      $display("test unmapped done");
      apb(1'b1, ISS_PIN_CTRL_ADDR, 32'h00F00100);
      repeat (2) @(posedge clk);
      chk("pin_en", 32'h0100, {16'h0, pin_en});
      chk("pin_dir", 32'h00F0, {16'h0, pin_dir});
      $display("test pin_control done");
      // Reset in mid-run returns every selector to its default source
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      lo = 32'h250718A4;
      hi = 32'h08202D43;
      rdchk(ISS_SEL_LOW_ADDR, lo, "sel_low_rst");
      rdchk(ISS_SEL_HIGH_ADDR, hi, "sel_high_rst");
      chk("pin_en_rst", 32'h0, {16'h0, pin_en});
      ev(32'h00000010);
      $display("test second_reset done");
      summarize();
   end
endmodule
`default_nettype wire
